// [rtl/tap_defines.svh]
// Constants of the boundary-scan test access port
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

`define TAP_IR_WIDTH      4
`define TAP_OP_EXTEST     4'h0
`define TAP_OP_SAMPLE     4'h1
`define TAP_OP_IDCODE     4'h2
`define TAP_OP_CLAMP      4'h3
`define TAP_OP_HIGHZ      4'h4
`define TAP_OP_BYPASS     4'hF
`define TAP_IR_CAPTURE    4'h1

`define TAP_ID_WIDTH      32
`define TAP_ID_VER_MSB    31
`define TAP_ID_VER_LSB    28
`define TAP_ID_PART_MSB   27
`define TAP_ID_PART_LSB   12
`define TAP_ID_MFR_MSB    11
`define TAP_ID_MFR_LSB    1
`define TAP_ID_FIXED_BIT  1'h1

`define TAP_PIN_COUNT     8
`define TAP_SYNC_RESET    1'h0

`endif

// [rtl/tap_pkg.sv]
// Types shared by the test access port files
package tap_pkg;

	// Raw test port inputs as they arrive from the board
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jtag_in_t;

	typedef struct packed {
		logic tdo_out;
		logic tdo_oe_n;
	} jtag_out_t;

	typedef enum logic [15:0] {
		TEST_LOGIC_RESET = 16'h0001,
		RUN_TEST_IDLE    = 16'h0002,
		SELECT_DR        = 16'h0004,
		CAPTURE_DR       = 16'h0008,
		SHIFT_DR         = 16'h0010,
		EXIT1_DR         = 16'h0020,
		PAUSE_DR         = 16'h0040,
		EXIT2_DR         = 16'h0080,
		UPDATE_DR        = 16'h0100,
		SELECT_IR        = 16'h0200,
		CAPTURE_IR       = 16'h0400,
		SHIFT_IR         = 16'h0800,
		EXIT1_IR         = 16'h1000,
		PAUSE_IR         = 16'h2000,
		EXIT2_IR         = 16'h4000,
		UPDATE_IR        = 16'h8000
	} tap_state_t;

endpackage

// [rtl/pin_sync.sv]
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`include "tap_defines.svh"

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= {WIDTH{`TAP_SYNC_RESET}};
			q    <= {WIDTH{`TAP_SYNC_RESET}};
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // pin_sync

// [rtl/boundary_scan_tap.sv]
// Boundary-scan test access port: TAP controller, instruction and data registers
`timescale 1ns/1ps
`include "tap_defines.svh"

module boundary_scan_tap #(
	parameter int          PINS    = `TAP_PIN_COUNT,
	parameter logic [3:0]  VERSION = 4'h3,      // Arbitrary value
	parameter logic [15:0] PART    = 16'hA5C3,  // Arbitrary value
	parameter logic [10:0] MAKER   = 11'h2B5    // Arbitrary value
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire tap_pkg::jtag_in_t  jtag_in,
	output tap_pkg::jtag_out_t      jtag_out,
	output logic                    trst_pull_en,
	input  wire logic [PINS-1:0]    pin_in,
	input  wire logic [PINS-1:0]    core_out,
	input  wire logic               core_drive,
	output logic [PINS-1:0]         pin_out,
	output logic                    pin_oe_n,
	output logic [PINS-1:0]         core_in
);
	import tap_pkg::*;

	localparam int BW = PINS + 1;

	jtag_in_t                  jin;
	logic                      tck_d;
	logic [PINS-1:0]           pin_s;
	tap_state_t                state;
	logic [`TAP_IR_WIDTH-1:0]  ir;
	logic [`TAP_IR_WIDTH-1:0]  ir_sr;
	logic                      bypass_sr;
	logic [`TAP_ID_WIDTH-1:0]  id_sr;
	logic [BW-1:0]             bsr;
	logic [BW-1:0]             bsr_upd;

	// All test pins and the sampled device pins cross into clk
	pin_sync #(.WIDTH(4)) u_jtag_sync (
		.clk (clk),
		.rst (rst),
		.d   (jtag_in),
		.q   (jin)
	);
	pin_sync #(.WIDTH(PINS)) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_in),
		.q   (pin_s)
	);

	function automatic tap_state_t next_tap(input tap_state_t s, input logic tms);
		case (s)
			TEST_LOGIC_RESET: next_tap = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE:    next_tap = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR:        next_tap = tms ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR:       next_tap = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR:         next_tap = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR:         next_tap = tms ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR:         next_tap = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR:         next_tap = tms ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR:        next_tap = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR:        next_tap = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR:       next_tap = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR:         next_tap = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR:         next_tap = tms ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR:         next_tap = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR:         next_tap = tms ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR:        next_tap = tms ? SELECT_DR : RUN_TEST_IDLE;
			default:          next_tap = TEST_LOGIC_RESET;
		endcase
	endfunction

	// A low test reset acts at once; only the two-flop delay separates it from the pin
	wire tap_rst  = rst | ~jin.trst_n;
	wire tck_rise = jin.tck & ~tck_d;
	wire tck_fall = ~jin.tck & tck_d;

	// Unknown opcodes fall back to bypass, as the standard asks
	wire op_extest = (ir == `TAP_OP_EXTEST);
	wire op_sample = (ir == `TAP_OP_SAMPLE);
	wire op_idcode = (ir == `TAP_OP_IDCODE);
	wire op_clamp  = (ir == `TAP_OP_CLAMP);
	wire op_highz  = (ir == `TAP_OP_HIGHZ);
	wire sel_bsr   = op_extest | op_sample;
	wire sel_bypass = ~(sel_bsr | op_idcode);

	wire [`TAP_ID_WIDTH-1:0] id_value;
	assign id_value[`TAP_ID_VER_MSB:`TAP_ID_VER_LSB]   = VERSION;
	assign id_value[`TAP_ID_PART_MSB:`TAP_ID_PART_LSB] = PART;
	assign id_value[`TAP_ID_MFR_MSB:`TAP_ID_MFR_LSB]   = MAKER;
	assign id_value[0]                                 = `TAP_ID_FIXED_BIT;

	wire in_shift_dr = (state == SHIFT_DR);
	wire in_shift_ir = (state == SHIFT_IR);
	wire dr_lsb      = op_idcode ? id_sr[0] : (sel_bsr ? bsr[0] : bypass_sr);
	wire next_tdo    = in_shift_ir ? ir_sr[0] : dr_lsb;

	// Boundary pins are driven by the test logic under EXTEST and CLAMP
	wire test_drive = op_extest | op_clamp;
	wire [PINS-1:0] next_pin_out = test_drive ? bsr_upd[PINS-1:0] : core_out;
	wire next_pin_oe_n = op_highz ? 1'h1 : (test_drive ? ~bsr_upd[PINS] : ~core_drive);
	wire [PINS-1:0] next_core_in = op_extest ? bsr_upd[PINS-1:0] : pin_s;

	always_ff @(posedge clk)
	begin
		if (rst)
			tck_d <= 1'h0;
		else
			tck_d <= jin.tck;
	end

	// Controller advances on the rising test clock
	always_ff @(posedge clk)
	begin
		if (tap_rst)
			state <= TEST_LOGIC_RESET;
		else if (tck_rise)
			state <= next_tap(state, jin.tms);
	end

	// Capture and shift on the rising test clock
	always_ff @(posedge clk)
	begin
		if (tap_rst)
		begin
			ir_sr     <= `TAP_IR_CAPTURE;
			bypass_sr <= 1'h0;
			id_sr     <= '0;
			bsr       <= '0;
		end
		else if (tck_rise)
		begin
			if (state == CAPTURE_IR)
				ir_sr <= `TAP_IR_CAPTURE;
			else if (in_shift_ir)
				ir_sr <= {jin.tdi, ir_sr[`TAP_IR_WIDTH-1:1]};
			if (state == CAPTURE_DR)
			begin
				bypass_sr <= 1'h0;
				if (op_idcode)
					id_sr <= id_value;
				if (sel_bsr)
					bsr <= {core_drive, pin_s};
			end
			else if (in_shift_dr)
			begin
				if (op_idcode)
					id_sr <= {jin.tdi, id_sr[`TAP_ID_WIDTH-1:1]};
				else if (sel_bsr)
					bsr <= {jin.tdi, bsr[BW-1:1]};
				else
					bypass_sr <= jin.tdi;
			end
		end
	end

	// Updates land on the falling test clock, so pins settle mid-cycle
	always_ff @(posedge clk)
	begin
		if (tap_rst)
		begin
			ir      <= `TAP_OP_IDCODE;
			bsr_upd <= '0;
		end
		else if (tck_fall)
		begin
			if (state == TEST_LOGIC_RESET)
				ir <= `TAP_OP_IDCODE;
			else if (state == UPDATE_IR)
				ir <= ir_sr;
			if (state == UPDATE_DR && sel_bsr)
				bsr_upd <= bsr;
		end
	end

	// Serial output follows the falling test clock and floats outside shifting
	always_ff @(posedge clk)
	begin
		if (tap_rst)
		begin
			jtag_out.tdo_out  <= 1'h0;
			jtag_out.tdo_oe_n <= 1'h1;
		end
		else if (tck_fall)
		begin
			jtag_out.tdo_out  <= next_tdo;
			jtag_out.tdo_oe_n <= ~(in_shift_dr | in_shift_ir);
		end
	end

	// Pins follow the core except when the test logic owns them
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_out      <= '0;
			pin_oe_n     <= 1'h1;
			core_in      <= '0;
			trst_pull_en <= 1'h0;
		end
		else
		begin
			pin_out      <= next_pin_out;
			pin_oe_n     <= next_pin_oe_n;
			core_in      <= next_core_in;
			trst_pull_en <= 1'h1;
		end
	end

endmodule // boundary_scan_tap

// [verif/boundary_scan_tap_sva.sv]
// Port-level assertions for the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_tap_sva #(
	parameter int PINS = 8
) (
	input wire logic               clk,
	input wire logic               rst,
	input wire tap_pkg::jtag_in_t  jtag_in,
	input wire tap_pkg::jtag_out_t jtag_out,
	input wire logic               trst_pull_en,
	input wire logic [PINS-1:0]    pin_in,
	input wire logic [PINS-1:0]    core_out,
	input wire logic               core_drive,
	input wire logic [PINS-1:0]    pin_out,
	input wire logic               pin_oe_n,
	input wire logic [PINS-1:0]    core_in
);
	import tap_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Synchronised tck lags the pin, so a move comes a few clk after the fall
	a_tdo_on_fall: assert property ($changed(jtag_out.tdo_out) |-> !jtag_in.tck && !$past(jtag_in.tck, 2))
		else $error("tdo moved near a rise");
	a_oe_on_fall: assert property ($changed(jtag_out.tdo_oe_n) |-> !jtag_in.tck && !$past(jtag_in.tck, 2))
		else $error("tdo enable moved near a rise");
	a_trst_floats: assert property ($fell(jtag_in.trst_n) |-> ##[1:6] jtag_out.tdo_oe_n)
		else $error("tdo driven after test reset");
	a_trst_held: assert property ((!jtag_in.trst_n) [*6] |-> jtag_out.tdo_oe_n)
		else $error("tdo driven in test reset");
	a_drive_after_trst: assert property (!jtag_out.tdo_oe_n |-> $past(jtag_in.trst_n, 6))
		else $error("tdo driven soon after test reset");
	a_core_pass: assert property ((!jtag_in.trst_n && $stable(pin_in)) [*8] |-> core_in == pin_in)
		else $error("core misses pins in test reset");
	a_pin_pass: assert property ((!jtag_in.trst_n && $stable(core_out) && $stable(core_drive)) [*8]
		|-> pin_out == core_out && pin_oe_n == !core_drive)
		else $error("pins not from core in test reset");
	a_pull_on: assert property (1'h1 |=> trst_pull_en)
		else $error("pull-down request missing");
endmodule // boundary_scan_tap_sva

bind boundary_scan_tap boundary_scan_tap_sva #(.PINS(PINS)) u_sva (.clk, .rst, .jtag_in, .jtag_out,
	.trst_pull_en, .pin_in, .core_out, .core_drive, .pin_out, .pin_oe_n, .core_in);

// [verif/jtag_tester.sv]
// Board-level test controller model driving the test port
`timescale 1ns/1ps
module jtag_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_v,
	output logic      trst_oe,
	input  wire logic tdo
);
	// Unused port: clock still, mode and data high, reset held low
	initial
	begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		trst_v = 1'h0;
		trst_oe = 1'h1;
	end
	task automatic pin(input logic v, input logic oe);
		trst_v = v;
		trst_oe = oe;
	endtask
	// Tdo is taken at the rise, where it has stood since the last fall
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#62.5;
		q = tdo;
		tck = 1'h1;
		#62.5;
		tck = 1'h0;
	endtask
endmodule // jtag_tester

// [verif/boundary_scan_tap_test.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "tap_defines.svh"
module boundary_scan_tap_test;
	import tap_pkg::*;
	// Identity values are arbitrary
	localparam logic [3:0]  VER = 4'h6;
	localparam logic [15:0] PRT = 16'h1E2D;
	localparam logic [10:0] MKR = 11'h0F1;
	localparam logic [63:0] ID  = {32'h0, VER, PRT, MKR, 1'h1};
	typedef struct {
		logic [3:0]  op;
		logic [63:0] din;
		logic [63:0] exp;
		int          n;
		logic        oe;
		logic [7:0]  pout;
	} row_t;
	row_t rows [7] = '{
		'{`TAP_OP_IDCODE, 64'h0, ID, 32, 1'h0, 8'hC3},
		'{`TAP_OP_SAMPLE, 64'h196, 64'h15A, 9, 1'h0, 8'hC3},
		'{`TAP_OP_EXTEST, 64'h196, 64'h15A, 9, 1'h0, 8'h96},
		'{`TAP_OP_CLAMP, 64'hAB, 64'h156, 9, 1'h0, 8'h96},
		'{`TAP_OP_HIGHZ, 64'hAB, 64'h156, 9, 1'h1, 8'h0},
		'{`TAP_OP_BYPASS, 64'hAB, 64'h156, 9, 1'h0, 8'hC3},
		'{4'h7, 64'hAB, 64'h156, 9, 1'h0, 8'hC3}
	};
	logic        clk, rst, core_drive, q, tck, tms, tdi, trst_v, trst_oe, pin_oe_n, trst_pull_en;
	logic [7:0]  pin_in, core_out, pin_out, core_in;
	logic [63:0] dout;
	int          mismatches, num_checks;
	jtag_in_t    ji;
	jtag_out_t   jo;
	wire         tdo = jo.tdo_oe_n ? 1'hZ : jo.tdo_out;
	// The pull-down acts only while the tester leaves the pin undriven
	assign ji = '{tck, tms, tdi, trst_oe ? trst_v : !trst_pull_en};
	boundary_scan_tap #(.PINS(8), .VERSION(VER), .PART(PRT), .MAKER(MKR)) u_dut (.clk, .rst, .jtag_in(ji),
		.jtag_out(jo), .trst_pull_en, .pin_in, .core_out, .core_drive, .pin_out, .pin_oe_n, .core_in);
	jtag_tester u_jt (.tck, .tms, .tdi, .trst_v, .trst_oe, .tdo);
	function automatic logic ck(input logic bad);
		num_checks++;
		return bad;
	endfunction
	task automatic err(input string s);
		mismatches++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic walk(input logic [3:0] p, input int k);
		for (int i = 0; i < k; i++)
			u_jt.step(p[i], 1'h0, q);
	endtask
	task automatic ir(input logic [3:0] op);
		logic [3:0] c;
		walk(4'h3, 4);
		for (int i = 0; i < 4; i++)
			u_jt.step(i == 3, op[i], c[i]);
		walk(4'h1, 2);
		if (ck(c !== `TAP_IR_CAPTURE)) err("ir capture");
	endtask
	task automatic dr(input logic [63:0] d, input int n);
		walk(4'h1, 3);
		for (int i = 0; i < n; i++)
			u_jt.step(i == n - 1, d[i], dout[i]);
		walk(4'h1, 2);
		#40;
		if (ck(jo.tdo_oe_n !== 1'h1)) err("tdo driven when idle");
	endtask
	task automatic final_report;
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#200000;
		err("timeout");
		final_report;
	end
	initial
	begin
		rst = 1'h1;
		pin_in = 8'h5A;
		core_out = 8'hC3;
		core_drive = 1'h1;
		mismatches = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		#1 rst = 1'h0;
		if (ck(jo.tdo_oe_n !== 1'h1 || pin_oe_n !== 1'h1 || core_in !== 8'h0)) err("reset value");
		@(posedge clk);
		#1;
		if (ck(trst_pull_en !== 1'h1)) err("no pull-down");
		u_jt.pin(1'h1, 1'h1);
		#100;
		walk(4'h0, 1);
		foreach (rows[k])
		begin
			ir(rows[k].op);
			dr(rows[k].din, rows[k].n);
			if (ck((dout & ((64'h1 << rows[k].n) - 64'h1)) !== rows[k].exp)) err("capture");
			if (ck(pin_oe_n !== rows[k].oe)) err("pin enable");
			if (ck(!rows[k].oe && pin_out !== rows[k].pout)) err("pin value");
			if (ck(core_in !== (rows[k].op == `TAP_OP_EXTEST ? 8'h96 : 8'h5A))) err("core value");
		end
		// Five high mode bits reach reset from any state and hand the pins back to the core
		ir(`TAP_OP_EXTEST);
		walk(4'hF, 4);
		walk(4'h1, 2);
		#40;
		if (ck(pin_out !== 8'hC3 || core_in !== 8'h5A)) err("soft reset kept extest");
		// Test reset lands in mid-shift with the clock standing still
		ir(`TAP_OP_EXTEST);
		walk(4'h1, 3);
		#40;
		if (ck(jo.tdo_oe_n !== 1'h0)) err("tdo idle in shift");
		u_jt.pin(1'h0, 1'h1);
		#40;
		if (ck(jo.tdo_oe_n !== 1'h1)) err("test reset ignored");
		if (ck(pin_out !== 8'hC3 || core_in !== 8'h5A)) err("test reset kept extest");
		u_jt.pin(1'h1, 1'h1);
		#40;
		walk(4'h0, 1);
		dr(64'h0, 32);
		if (ck(dout[31:0] !== ID[31:0])) err("ir not reset");
		// A pause in mid-shift must neither lose nor repeat a bit
		walk(4'h1, 3);
		for (int i = 0; i < 32; i++)
		begin
			u_jt.step(i == 9 || i == 31, 1'h0, dout[i]);
			if (i == 9)
			begin
				walk(4'h0, 2);
				if (ck(jo.tdo_oe_n !== 1'h1)) err("tdo driven in pause");
				walk(4'h1, 2);
			end
		end
		walk(4'h1, 2);
		if (ck(dout[31:0] !== ID[31:0])) err("pause upset shift");
		u_jt.pin(1'h0, 1'h0);
		#40;
		walk(4'h1, 3);
		#40;
		if (ck(jo.tdo_oe_n !== 1'h1)) err("undriven reset left logic active");
		// Outside the test instructions the pin enable follows the core
		@(posedge clk);
		#1 core_drive = 1'h0;
		repeat (2) @(posedge clk);
		#1;
		if (ck(pin_oe_n !== 1'h1)) err("pins driven without core enable");
		final_report;
	end
endmodule // boundary_scan_tap_test
